// ==== hw/psm_pkg.sv ====
`default_nettype none
package psm_pkg;
	// Clock and time base
	localparam int CLK_MHZ         = 100;
	localparam int TICK_US         = 1000;
	localparam int TICK_CYCLES_DEF = TICK_US * CLK_MHZ;
	localparam int DEB_MS          = 10;
	localparam int DEB_CYCLES_DEF  = DEB_MS * 1000 * CLK_MHZ;
	localparam int TICK_W          = 17;
	localparam int DEB_W           = 20;

	// Delay registers hold counts of 1 ms ticks
	localparam int TD_W = 16;

	// Register byte addresses
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_TD_PTOS    = 8'h04;
	localparam logic [7:0] REG_TD_STOP    = 8'h08;
	localparam logic [7:0] REG_TD_OFF_SBY = 8'h0C;
	localparam logic [7:0] REG_TD_OFF_PRF = 8'h10;
	localparam logic [7:0] REG_TD_START_N = 8'h14;
	localparam logic [7:0] REG_TD_START_E = 8'h18;
	localparam logic [7:0] REG_TD_COOL_N  = 8'h1C;
	localparam logic [7:0] REG_TD_COOL_E  = 8'h20;
	localparam logic [7:0] REG_STATUS     = 8'h24;

	// Index of each delay in the delay array (word index minus one)
	localparam logic [2:0] TD_PTOS    = 3'h0;
	localparam logic [2:0] TD_STOP    = 3'h1;
	localparam logic [2:0] TD_OFF_SBY = 3'h2;
	localparam logic [2:0] TD_OFF_PRF = 3'h3;
	localparam logic [2:0] TD_START_N = 3'h4;
	localparam logic [2:0] TD_COOL_N  = 3'h6;
	localparam logic [TD_W-1:0] TD_RESET = 16'h0000;

	// Control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_PROG_BIT = 2;

	// Status register fields
	localparam int ST_PREF_E = 0;
	localparam int ST_STATE  = 1;
	localparam int ST_CONN_N = 4;
	localparam int ST_CONN_E = 5;
	localparam int ST_RUN_N  = 6;
	localparam int ST_RUN_E  = 7;
	localparam int ST_FAIL   = 8;

	// Physical sides
	localparam logic SIDE_N = 1'b0;
	localparam logic SIDE_E = 1'b1;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		PSM_GEN_UTIL  = 2'b00,
		PSM_GEN_GEN   = 2'b01,
		PSM_UTIL_UTIL = 2'b10
	} psm_mode_t;

	typedef enum logic [2:0] {
		PSM_S_OFF  = 3'b000,
		PSM_S_ON_N = 3'b001,
		PSM_S_ON_E = 3'b010,
		PSM_S_WAIT = 3'b011,
		PSM_S_OPEN = 3'b100
	} psm_state_t;
endpackage
`default_nettype wire

// ==== hw/psm_debounce.sv ====
`default_nettype none
module psm_debounce #(
	parameter int DEB_CYCLES = psm_pkg::DEB_CYCLES_DEF
) (
	// Clock and control
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic ce,
	// Raw selector pin and settled level
	input  wire logic pin_raw,
	output logic      stable
);
	import psm_pkg::*;

	logic              sync1;
	logic              sync2;
	logic [DEB_W-1:0]  cnt;
	logic [DEB_W-1:0]  next_cnt;
	logic              next_stable;

	// Settle only after the level has held for the whole window
	always_comb begin
		next_cnt    = '0;
		next_stable = stable;
		if (sync2 != stable) begin
			next_cnt = cnt + 1'b1;
			if (cnt == DEB_W'(DEB_CYCLES - 1)) begin
				next_stable = sync2;
				next_cnt    = '0;
			end
		end
	end

	// Two-stage synchroniser, then the counter
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sync1  <= 1'b0;
			sync2  <= 1'b0;
			cnt    <= '0;
			stable <= 1'b0;
		end else if (ce) begin
			sync1  <= pin_raw;
			sync2  <= sync1;
			cnt    <= next_cnt;
			stable <= next_stable;
		end
	end
endmodule
`default_nettype wire

// ==== hw/psm_timer.sv ====
`default_nettype none
module psm_timer (
	// Clock and control
	input  wire logic                   clock,
	input  wire logic                   sys_rst,
	input  wire logic                   ce,
	input  wire logic                   tick,
	// Commands
	input  wire logic                   start,
	input  wire logic                   clear,
	input  wire logic [psm_pkg::TD_W-1:0] load_val,
	// Expiry, held until the next start or clear
	output logic                        done
);
	import psm_pkg::*;

	logic [TD_W-1:0] cnt;
	logic [TD_W-1:0] next_cnt;
	logic            armed;
	logic            next_armed;
	logic            next_done;

	// Clear wins over start so an abandoned delay cannot fire
	always_comb begin
		next_cnt   = cnt;
		next_armed = armed;
		next_done  = done;
		if (clear) begin
			next_armed = 1'b0;
			next_done  = 1'b0;
		end else if (start) begin
			next_cnt   = load_val;
			next_armed = 1'b1;
			next_done  = 1'b0;
		end else if (armed && cnt == '0) begin
			next_armed = 1'b0;
			next_done  = 1'b1;
		end else if (armed && tick) begin
			next_cnt = cnt - 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cnt   <= '0;
			armed <= 1'b0;
			done  <= 1'b0;
		end else if (ce) begin
			cnt   <= next_cnt;
			armed <= next_armed;
			done  <= next_done;
		end
	end
endmodule
`default_nettype wire

// ==== hw/psm_mapper.sv ====
// How it works
// - Local two-position selector picks preferred source
// - No remote path can change the preference
// - Seek and transfer to preferred when available
// - Engine start relays stay on their side
// - Reset mode is generator-to-utility, one start
// - Emergency preferred: generator runs, utility on failure
// - Generator-generator adds normal-side start output
// - Utility-utility drives no engine start output
// - Start delays and trip points stay per side
// - Cooldown delays applied per physical side
// - In-phase monitor always references emergency side
// - Role parameters re-steer when preference changes
// - Transfer delays chosen by preferred/standby direction
// - Standby acquire failure watches non-preferred side
// - Pretransfer signals follow preferred and standby roles
// - Post-transfer signals follow roles likewise
// - Programmed transition: off delays by role
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`default_nettype none
module psm_mapper #(
	parameter int TICK_CYCLES = psm_pkg::TICK_CYCLES_DEF,
	parameter int DEB_CYCLES  = psm_pkg::DEB_CYCLES_DEF
) (
	// Clock, reset, enable
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        ce,
	// Local selector pin, high selects emergency side
	input  wire logic        pref_sel_pin,
	// Source acceptable flags from per-side trip monitors
	input  wire logic        src_avail_n,
	input  wire logic        src_avail_e,
	// Contactor and engine start relays
	output logic             close_n,
	output logic             close_e,
	output logic             gen_start_n,
	output logic             gen_start_e,
	// Role-based signals, fixed emergency-side in-phase reference, preference flag
	output logic             pre_to_pref,
	output logic             pre_to_sby,
	output logic             post_to_pref,
	output logic             post_to_sby,
	output logic             fail_acq_sby,
	output logic             sync_ref_e,
	output logic             pref_is_e,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import psm_pkg::*;

	// Aligned word inside the map
	function automatic logic addr_ok(input logic [7:0] a);
		return a[1:0] == 2'b00 && a <= REG_STATUS;
	endfunction

	// Contactor state that closes onto a side
	function automatic psm_state_t on_state(input logic side);
		return side ? PSM_S_ON_E : PSM_S_ON_N;
	endfunction

	// Byte-lane merge into a 16-bit delay
	function automatic logic [TD_W-1:0] merge16(input logic [TD_W-1:0] old,
			input logic [31:0] d, input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	logic                sel_stable;
	logic                pref_q;
	logic                tick;
	logic [TICK_W-1:0]   tick_cnt;
	psm_mode_t           mode;
	logic                prog_trans;
	logic [TD_W-1:0]     td [8];
	logic [1:0]          avail;
	logic [31:0]         status_word;

	// Selector: pin passes synchroniser and debounce first
	psm_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb (
		.clock   (clock),
		.sys_rst (sys_rst),
		.ce      (ce),
		.pin_raw (pref_sel_pin),
		.stable  (sel_stable)
	);

	assign avail = {src_avail_e, src_avail_n};

	// Preference and tick base; only the local selector feeds pref_q
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pref_q     <= SIDE_N;
			tick_cnt   <= '0;
			tick       <= 1'b0;
			sync_ref_e <= 1'b1;
		end else if (ce) begin
			pref_q     <= sel_stable;
			tick       <= tick_cnt == TICK_W'(TICK_CYCLES - 1);
			tick_cnt   <= (tick_cnt == TICK_W'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
			sync_ref_e <= 1'b1;
		end
	end
	assign pref_is_e = pref_q;

	// Per-side engine start logic, never indexed by preference
	logic run [2];
	logic sdone [2];
	generate
		for (genvar s = 0; s < 2; s++) begin : g_side
			logic need;
			logic need_q;
			logic en;
			logic cdone;
			logic next_run;
			// Preferred side always needed; standby when the other is lost
			assign need = (pref_q == 1'(s)) || !avail[1 - s];
			assign en   = (s == 0) ? (mode == PSM_GEN_GEN) : (mode != PSM_UTIL_UTIL);
			psm_timer u_start (
				.clock (clock), .sys_rst (sys_rst), .ce (ce), .tick (tick),
				.start (need && !need_q), .clear (!need),
				.load_val (td[TD_START_N + 3'(s)]),
				.done  (sdone[s])
			);
			psm_timer u_cool (
				.clock (clock), .sys_rst (sys_rst), .ce (ce), .tick (tick),
				.start (!need && need_q && run[s]), .clear (need),
				.load_val (td[TD_COOL_N + 3'(s)]),
				.done  (cdone)
			);
			// Run after start delay, keep through cooldown
			assign next_run = en && ((need && sdone[s]) || (run[s] && !need && !cdone));
			always_ff @(posedge clock) begin
				if (sys_rst) begin
					need_q <= 1'b0;
					run[s] <= 1'b0;
				end else if (ce) begin
					need_q <= need;
					run[s] <= next_run;
				end
			end
		end
	endgenerate
	assign gen_start_n = run[0];
	assign gen_start_e = run[1];

	// Transfer sequencer
	psm_state_t       state;
	psm_state_t       next_state;
	logic             tgt;
	logic             next_tgt;
	logic             next_close_n;
	logic             next_close_e;
	logic             next_post_pref;
	logic             next_post_sby;
	logic             next_fail;
	logic             x_start;
	logic             x_clear;
	logic             x_done;
	logic [TD_W-1:0]  x_load;
	logic             want;
	logic             want_ok;

	psm_timer u_xfer (
		.clock (clock), .sys_rst (sys_rst), .ce (ce), .tick (tick),
		.start (x_start), .clear (x_clear), .load_val (x_load), .done (x_done)
	);

	// Roles resolve against pref_q every cycle, so a selector change re-steers at once
	always_comb begin
		want           = avail[pref_q] ? pref_q : !pref_q;
		want_ok        = avail[want];
		next_state     = state;
		next_tgt       = tgt;
		next_close_n   = close_n;
		next_close_e   = close_e;
		next_post_pref = 1'b0;
		next_post_sby  = 1'b0;
		x_start        = 1'b0;
		x_clear        = 1'b0;
		x_load         = td[TD_PTOS];
		case (state)
			PSM_S_OFF: begin
				if (want_ok) begin
					next_tgt   = want;
					next_state = on_state(want);
				end
			end
			PSM_S_ON_N, PSM_S_ON_E: begin
				if (want_ok && want != (state == PSM_S_ON_E)) begin
					next_tgt   = want;
					x_start    = 1'b1;
					x_load     = (want == pref_q) ? td[TD_STOP] : td[TD_PTOS];
					next_state = PSM_S_WAIT;
				end
			end
			PSM_S_WAIT: begin
				if (!want_ok || want != tgt) begin
					x_clear    = 1'b1;
					next_tgt   = !tgt;
					next_state = on_state(!tgt);
				end else if (x_done && prog_trans) begin
					next_close_n = 1'b0;
					next_close_e = 1'b0;
					x_start      = 1'b1;
					x_load       = (tgt == pref_q) ? td[TD_OFF_PRF] : td[TD_OFF_SBY];
					next_state   = PSM_S_OPEN;
				end else if (x_done) begin
					x_clear    = 1'b1;
					next_state = on_state(tgt);
				end
			end
			PSM_S_OPEN: begin
				if (!avail[tgt]) begin
					x_clear    = 1'b1;
					next_state = PSM_S_OFF;
				end else if (x_done) begin
					x_clear    = 1'b1;
					next_state = on_state(tgt);
				end
			end
			default: next_state = PSM_S_OFF;
		endcase
		// Every closing onto a side issues the role's post-transfer pulse
		if (next_state != state && (next_state == PSM_S_ON_N || next_state == PSM_S_ON_E)) begin
			next_close_n   = next_state == PSM_S_ON_N;
			next_close_e   = next_state == PSM_S_ON_E;
			next_post_pref = next_tgt == pref_q;
			next_post_sby  = next_tgt != pref_q;
		end
		next_fail = !avail[pref_q] && !avail[!pref_q] && sdone[!pref_q];
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state        <= PSM_S_OFF;
			tgt          <= SIDE_N;
			close_n      <= 1'b0;
			close_e      <= 1'b0;
			pre_to_pref  <= 1'b0;
			pre_to_sby   <= 1'b0;
			post_to_pref <= 1'b0;
			post_to_sby  <= 1'b0;
			fail_acq_sby <= 1'b0;
		end else if (ce) begin
			state        <= next_state;
			tgt          <= next_tgt;
			close_n      <= next_close_n;
			close_e      <= next_close_e;
			pre_to_pref  <= next_state == PSM_S_WAIT && next_tgt == pref_q;
			pre_to_sby   <= next_state == PSM_S_WAIT && next_tgt != pref_q;
			post_to_pref <= next_post_pref;
			post_to_sby  <= next_post_sby;
			fail_acq_sby <= next_fail;
		end
	end

	// Status view; preference is read-only here
	always_comb begin
		status_word                         = '0;
		status_word[ST_PREF_E]              = pref_q;
		status_word[ST_STATE +: 3]          = state;
		status_word[ST_CONN_N]              = close_n;
		status_word[ST_CONN_E]              = close_e;
		status_word[ST_RUN_N]               = run[0];
		status_word[ST_RUN_E]               = run[1];
		status_word[ST_FAIL]                = fail_acq_sby;
	end

	// AXI4-Lite slave: address and data held independently, then committed
	logic        aw_have, w_have, next_aw_have, next_w_have;
	logic [7:0]  aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0]  w_strb, next_w_strb;
	logic        next_bvalid, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;
	psm_mode_t   next_mode;
	logic        next_prog;
	logic [TD_W-1:0] next_td [8];
	logic [3:0]  widx, ridx;

	always_comb begin
		next_aw_have = aw_have || (s_axi_awvalid && s_axi_awready);
		next_aw_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr;
		next_w_have  = w_have || (s_axi_wvalid && s_axi_wready);
		next_w_data  = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data;
		next_w_strb  = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : w_strb;
		next_bvalid  = s_axi_bvalid && !s_axi_bready;
		next_bresp   = s_axi_bresp;
		next_mode    = mode;
		next_prog    = prog_trans;
		next_td      = td;
		widx         = aw_addr[5:2];
		ridx         = s_axi_araddr[5:2];
		if (aw_have && w_have && !s_axi_bvalid) begin
			next_aw_have = 1'b0;
			next_w_have  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = addr_ok(aw_addr) ? RESP_OKAY : RESP_SLVERR;
			if (addr_ok(aw_addr) && aw_addr == REG_CTRL && w_strb[0]) begin
				next_mode = psm_mode_t'(w_data[CTRL_MODE_LSB +: 2]);
				next_prog = w_data[CTRL_PROG_BIT];
			end else if (addr_ok(aw_addr) && aw_addr != REG_STATUS && aw_addr != REG_CTRL) begin
				next_td[3'(widx - 4'h1)] = merge16(td[3'(widx - 4'h1)], w_data, w_strb);
			end
		end
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rdata  = s_axi_rdata;
		next_rresp  = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			if (!addr_ok(s_axi_araddr))
				next_rdata = '0;
			else if (s_axi_araddr == REG_CTRL)
				next_rdata = {29'h0, prog_trans, mode};
			else if (s_axi_araddr == REG_STATUS)
				next_rdata = status_word;
			else
				next_rdata = {16'h0, td[3'(ridx - 4'h1)]};
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			aw_have       <= 1'b0;
			w_have        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
			mode          <= PSM_GEN_UTIL;
			prog_trans    <= 1'b0;
			td            <= '{default: TD_RESET};
		end else if (ce) begin
			aw_have       <= next_aw_have;
			w_have        <= next_w_have;
			aw_addr       <= next_aw_addr;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			s_axi_awready <= !next_aw_have && !next_bvalid;
			s_axi_wready  <= !next_w_have && !next_bvalid;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= !next_rvalid;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
			mode          <= next_mode;
			prog_trans    <= next_prog;
			td            <= next_td;
		end
	end

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	property p_pref_local;
		ce && $changed(pref_q) |-> $past(sel_stable) == pref_q;
	endproperty
	a_pref_local: assert property (p_pref_local) else $error("preference moved without selector");
	property p_seek_pref;
		ce && state == PSM_S_ON_E && !pref_q && avail[SIDE_N] |=> state == PSM_S_WAIT;
	endproperty
	a_seek_pref: assert property (p_seek_pref) else $error("preferred source not sought");
	property p_start_n_mode;
		gen_start_n |-> $past(mode) == PSM_GEN_GEN;
	endproperty
	a_start_n_mode: assert property (p_start_n_mode) else $error("normal start outside gen-gen");
	property p_uu_quiet;
		ce && mode == PSM_UTIL_UTIL ##1 ce |-> !gen_start_n && !gen_start_e;
	endproperty
	a_uu_quiet: assert property (p_uu_quiet) else $error("start output in utility-utility");
	property p_pre_role;
		pre_to_pref |-> state == PSM_S_WAIT && tgt == $past(pref_q) && !pre_to_sby;
	endproperty
	a_pre_role: assert property (p_pre_role) else $error("pretransfer role mismatch");
	property p_post_role;
		post_to_sby |-> (tgt != $past(pref_q)) && (close_e == tgt) && (close_n != tgt);
	endproperty
	a_post_role: assert property (p_post_role) else $error("post-transfer role mismatch");
	property p_open_gap;
		state == PSM_S_OPEN |-> !close_n && !close_e;
	endproperty
	a_open_gap: assert property (p_open_gap) else $error("contactor closed during off delay");
	property p_fail_sby;
		fail_acq_sby |-> !$past(avail[!pref_q]);
	endproperty
	a_fail_sby: assert property (p_fail_sby) else $error("failure flag with standby present");
	property p_sync_e;
		ce |=> sync_ref_e;
	endproperty
	a_sync_e: assert property (p_sync_e) else $error("in-phase reference left emergency side");

	c_transfer: cover property (state == PSM_S_WAIT ##[1:1000] post_to_pref);
	c_prog_open: cover property (state == PSM_S_OPEN ##[1:1000] close_e);
	c_gen_run: cover property (pref_q && gen_start_e);
endmodule
`default_nettype wire

// ==== verif/psm_plant.sv ====
`default_nettype none
module psm_plant #(
	parameter int RUN = 5
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic sys_rst,
	// Engine start relays
	input  wire logic gen_start_n,
	input  wire logic gen_start_e,
	// Scenario controls
	input  wire logic grid_n,
	input  wire logic grid_e,
	input  wire logic fail_e,
	// Source acceptable flags
	output logic      avail_n,
	output logic      avail_e
);
	int cnt_n = 0;
	int cnt_e = 0;

	// Each engine answers only its own relay, RUN cycles to speed
	always @(posedge clock) begin
		cnt_n <= (sys_rst || !gen_start_n) ? 0 : (cnt_n < RUN ? cnt_n + 1 : RUN);
		cnt_e <= (sys_rst || !gen_start_e || fail_e) ? 0 : (cnt_e < RUN ? cnt_e + 1 : RUN);
	end

	// A failed engine drops its source at once, no grace period
	assign avail_n = grid_n | (cnt_n == RUN);
	assign avail_e = grid_e | (cnt_e == RUN && !fail_e);
endmodule
`default_nettype wire

// ==== verif/psm_mapper_tb_top.sv ====
`default_nettype none
module psm_mapper_tb_top import psm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DEB = 4;
	localparam int TICK = 10;
	logic        clock = 0, sys_rst = 1, pin = 0, clr = 0;
	logic        grid_n = 0, grid_e = 0, fail_e = 0, avail_n, avail_e;
	logic        close_n, close_e, gs_n, gs_e, pre_p, pre_s, post_p, post_s;
	logic        fail_acq, sync_e, pref_e;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, d;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, r, b;
	logic [6:0]  mon;
	logic [3:0]  seen = 0;
	int          n_fail = 0, num_checks = 0, cyc = 0;

	assign mon = {fail_acq, pref_e, sync_e, gs_e, gs_n, close_e, close_n};
	always #5 clock = ~clock;

	psm_mapper #(.TICK_CYCLES(TICK), .DEB_CYCLES(DEB)) uut (
		.clock(clock), .sys_rst(sys_rst), .ce(1'b1), .pref_sel_pin(pin),
		.src_avail_n(avail_n), .src_avail_e(avail_e),
		.close_n(close_n), .close_e(close_e), .gen_start_n(gs_n), .gen_start_e(gs_e),
		.pre_to_pref(pre_p), .pre_to_sby(pre_s), .post_to_pref(post_p),
		.post_to_sby(post_s), .fail_acq_sby(fail_acq), .sync_ref_e(sync_e),
		.pref_is_e(pref_e), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	psm_plant plant (
		.clock(clock), .sys_rst(sys_rst), .gen_start_n(gs_n), .gen_start_e(gs_e),
		.grid_n(grid_n), .grid_e(grid_e), .fail_e(fail_e),
		.avail_n(avail_n), .avail_e(avail_e));

	// Sticky record of one-cycle post-transfer pulses and pretransfer flags held through the wait, so checks need not hit the edge
	always @(posedge clock)
		seen <= clr ? 4'h0 : seen | {pre_s, pre_p, post_s, post_p};

	task automatic conclude;
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Hang guard, well above the expected run length
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask

	// Bounded poll on one monitored output, then judge it
	task automatic poll(input int i, input logic v, input string nm);
		int k;
		k = 0;
		while (mon[i] !== v && k < 200) begin
			@(posedge clock);
			k++;
		end
		chk(nm, {31'h0, v}, {31'h0, mon[i]});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dv);
		logic aw;
		logic w;
		@(posedge clock);
		awaddr <= a;
		wdata <= dv;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw = 1;
		w = 1;
		while (aw || w) begin
			@(posedge clock);
			if (aw && awready === 1'b1) begin
				awvalid <= 1'b0;
				aw = 0;
			end
			if (w && wready === 1'b1) begin
				wvalid <= 1'b0;
				w = 0;
			end
		end
		while (bvalid !== 1'b1) @(posedge clock);
		b = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clock); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic t_reset;
		chk("sync_ref", 1, sync_e);
		rd(REG_CTRL);
		chk("ctrl_rst", 0, d);
		rd(8'h28);
		chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
	endtask

	task automatic t_pref_n;
		grid_n <= 1'b1;
		poll(0, 1, "close_n");
		chk("gs_n_off", 0, gs_n);
		// Software must not move the preference, status bit 0 included
		wr(REG_STATUS, 32'h1);
		chk("status_wr", {30'h0, RESP_OKAY}, {30'h0, b});
		wr(REG_CTRL, 32'h0);
		repeat (DEB + 5) @(posedge clock);
		chk("pref_remote", 0, pref_e);
	endtask

	task automatic t_pref_e;
		clr <= 1'b1;
		pin <= 1'b1;
		@(posedge clock);
		clr <= 1'b0;
		poll(5, 1, "pref_e");
		poll(3, 1, "gs_e");
		poll(1, 1, "close_e");
		repeat (30) @(posedge clock);
		chk("stay_e", 1, close_e);
		chk("gs_n_fixed", 0, gs_n);
		chk("sync_e_pos", 1, sync_e);
		chk("pre_pref", 1, seen[2]);
		chk("post_pref", 1, seen[0]);
	endtask

	task automatic t_fail;
		clr <= 1'b1;
		fail_e <= 1'b1;
		@(posedge clock);
		clr <= 1'b0;
		poll(0, 1, "fail_to_n");
		repeat (2) @(posedge clock);
		chk("pre_sby", 1, seen[3]);
		chk("post_sby", 1, seen[1]);
		fail_e <= 1'b0;
		poll(1, 1, "back_e");
	endtask

	// Preferred E to standby N must use the three-tick delay; the free tick
	// may land early in the first tick, so the floor is two whole ticks
	task automatic t_ptos;
		int n;
		wr(REG_TD_PTOS, 32'h3);
		fail_e <= 1'b1;
		n = 0;
		while (close_n !== 1'b1 && n < 200) begin
			@(posedge clock);
			n++;
		end
		chk("ptos_time", 1, n >= 2 * TICK && n <= 3 * TICK + 6);
		fail_e <= 1'b0;
		grid_n <= 1'b0;
		poll(6, 1, "fail_acq");
		grid_n <= 1'b1;
		poll(1, 1, "ret_e");
	endtask

	task automatic t_modes;
		grid_e <= 1'b1;
		wr(REG_CTRL, 32'h2);
		poll(3, 0, "uu_gs_e");
		chk("uu_gs_n", 0, gs_n);
		wr(REG_CTRL, 32'h1);
		pin <= 1'b0;
		poll(2, 1, "gg_gs_n");
		pin <= 1'b1;
		poll(3, 1, "gg_gs_e");
	endtask

	// Programmed transition: both sides open for the off-to-preferred delay
	task automatic t_prog;
		int n;
		wr(REG_CTRL, 32'h4);
		wr(REG_TD_OFF_PRF, 32'h2);
		pin <= 1'b0;
		poll(1, 0, "prog_open_e");
		chk("prog_open_n", 0, close_n);
		n = 0;
		while (close_n !== 1'b1 && n < 200) begin
			@(posedge clock);
			n++;
		end
		chk("off_pref_time", 1, n >= TICK && n <= 2 * TICK + 4);
	endtask

	initial begin
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		t_pref_n();
		t_pref_e();
		t_fail();
		t_ptos();
		t_modes();
		t_prog();
		conclude();
	end
endmodule
`default_nettype wire
